// [crb_pkg.sv]
// package for the config rom header and bus info block registers
package crb_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CRB_OFF_HEADER = 8'h00;
  localparam logic [7:0] CRB_OFF_BUS_IDENTIFIER = 8'h04;
  localparam logic [7:0] CRB_OFF_OPTIONS = 8'h08;
  localparam logic [7:0] CRB_OFF_CONTROL = 8'h0c;
  localparam logic [7:0] CRB_OFF_STATUS = 8'h10;

  // ---------------------------------------------------------------
  // remote quadlet selectors
  // ---------------------------------------------------------------
  localparam logic [2:0] CRB_Q_HEADER = 3'h0;
  localparam logic [2:0] CRB_Q_BUS_IDENTIFIER = 3'h1;
  localparam logic [2:0] CRB_Q_OPTIONS = 3'h2;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CRB_HDR_INFO_LSB = 24;
  localparam int CRB_HDR_CRCLEN_LSB = 16;
  localparam int CRB_HDR_CRC_LSB = 0;
  localparam int CRB_OPT_IRM_BIT = 31;
  localparam int CRB_OPT_CM_BIT = 30;
  localparam int CRB_OPT_ISO_BIT = 29;
  localparam int CRB_OPT_BM_BIT = 28;
  localparam int CRB_OPT_PM_BIT = 27;
  localparam int CRB_OPT_ACC_LSB = 16;
  localparam int CRB_OPT_MAXREC_LSB = 12;
  localparam int CRB_OPT_GEN_LSB = 6;
  localparam int CRB_OPT_SPD_LSB = 0;
  localparam int CRB_CTL_LINK_EN_BIT = 0;
  localparam int CRB_CTL_SOFT_RST_BIT = 1;

  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [31:0] CRB_HDR_HARD_RST = 32'h00000000;
  localparam logic [31:0] CRB_BUS_IDENT_VALUE = 32'h31333934;
  localparam logic [31:0] CRB_OPT_HARD_RST = 32'h00000000;
  localparam logic [3:0] CRB_MAXREC_DEF = 4'h8;
  localparam logic [2:0] CRB_LINK_SPD_DEF = 3'h2;

  // ---------------------------------------------------------------
  // axi responses
  // ---------------------------------------------------------------
  localparam logic [1:0] CRB_RESP_OKAY = 2'h0;
  localparam logic [1:0] CRB_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CRB_W_IDLE = 2'b00,
    CRB_W_RESP = 2'b01
  } crb_wstate_t;

endpackage

// [crb_quad_mux.sv]
// registered quadlet selector for remote configuration rom reads
`timescale 1ns/1ns
`default_nettype none
module crb_quad_mux (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic req,
  input wire logic [2:0] sel,
  // sources
  input wire logic [31:0] header_q,
  input wire logic [31:0] ident_q,
  input wire logic [31:0] options_q,
  // answer
  output logic valid,
  output logic [31:0] data
);
  import crb_pkg::*;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } crb_qm_state_t;

  crb_qm_state_t cur_ff;
  crb_qm_state_t nxt_cur;

  // pick the quadlet for the requested location
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.valid = req;
    if (req) begin
      case (sel)
        CRB_Q_HEADER: nxt_cur.data = header_q;
        CRB_Q_BUS_IDENTIFIER: nxt_cur.data = ident_q;
        CRB_Q_OPTIONS: nxt_cur.data = options_q;
        default: nxt_cur.data = 32'h00000000;
      endcase
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign valid = cur_ff.valid;
  assign data = cur_ff.data;
endmodule
`default_nettype wire

// [crb_regs.sv]
// config rom header and bus info block register bank
// How it works
// - the header register is returned as rom quadlet 0 to remote reads.
// - header info length, crc length and crc are writable, zero on hard reset.
// - a soft reset leaves the header fields alone.
// - the bus ident register is read only 1394 ascii, quadlet one remotely.
// - the bus options register is returned as bus info quadlet two.
// - capability flags and clock accuracy are writable, zero on hard reset.
// - max receive loads its default code MAXREC_DEF (8) on hard reset, not on soft reset.
// - block writes longer than max receive get a type error acknowledge.
// - link speed loads its maximum on hard reset and is reloaded to it on soft reset.
// - packets up to the size of the reported speed are accepted.
// - link speed may be set to any code up to its maximum, larger writes clamp to it; faster incoming packets are rejected.
// - options bits 3-5, 8-11 and 24-26 are plain writable storage.
`timescale 1ns/1ns
`default_nettype none
module crb_regs #(
  parameter logic [3:0] MAXREC_DEF = crb_pkg::CRB_MAXREC_DEF,
  parameter logic [2:0] LINK_SPD_MAX = crb_pkg::CRB_LINK_SPD_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // remote configuration rom read port
  input wire logic rom_rd_req,
  input wire logic [2:0] rom_rd_sel,
  output logic rom_rd_valid,
  output logic [31:0] rom_rd_data,
  // received packet check
  input wire logic pkt_chk,
  input wire logic pkt_is_blk_wr,
  input wire logic [15:0] pkt_len,
  input wire logic [2:0] pkt_spd,
  output logic pkt_ok,
  output logic pkt_type_err,
  output logic pkt_spd_rej,
  // control seen by the link
  output logic link_enable_bit,
  output logic [2:0] link_spd
);
  import crb_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    crb_wstate_t wst;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] header;
    logic [31:0] options;
    logic link_en;
    logic pkt_ok;
    logic pkt_type_err;
    logic pkt_spd_rej;
  } crb_state_t;

  crb_state_t cur_ff;
  crb_state_t nxt_cur;
  logic [31:0] bus_ident_value;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] crb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // size in bytes allowed by a max receive code: 2^(code+1)
  function automatic logic [16:0] crb_rec_bytes(input logic [3:0] code);
    return 17'(17'h2 << code);
  endfunction

  // largest async payload for a speed code (512 << speed)
  function automatic logic [16:0] crb_spd_bytes(input logic [2:0] spd);
    return 17'(17'h200 << spd);
  endfunction

  // word read back at a register offset
  function automatic logic [31:0] crb_rd_word(input logic [7:0] addr,
                                              input crb_state_t s);
    case (addr)
      CRB_OFF_HEADER: return s.header;
      CRB_OFF_BUS_IDENTIFIER: return CRB_BUS_IDENT_VALUE;
      CRB_OFF_OPTIONS: return s.options;
      CRB_OFF_CONTROL: return {31'h0, s.link_en};
      CRB_OFF_STATUS: return {29'h0, s.pkt_spd_rej, s.pkt_type_err,
                              s.pkt_ok};
      default: return 32'h00000000;
    endcase
  endfunction

  function automatic logic crb_mapped(input logic [7:0] addr);
    return (addr == CRB_OFF_HEADER) || (addr == CRB_OFF_BUS_IDENTIFIER) ||
           (addr == CRB_OFF_OPTIONS) || (addr == CRB_OFF_CONTROL) ||
           (addr == CRB_OFF_STATUS);
  endfunction

  assign bus_ident_value = CRB_BUS_IDENT_VALUE;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic [31:0] merged;
    logic [2:0] req_spd;
    merged = 32'h00000000;
    req_spd = 3'h0;
    nxt_cur = cur_ff;
    nxt_cur.awready = 1'b0;
    nxt_cur.wready = 1'b0;
    nxt_cur.arready = 1'b0;

    // write channel capture, address and data in either order
    if (s_axi_awvalid && cur_ff.awready) begin
      nxt_cur.aw_got = 1'b1;
      nxt_cur.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur_ff.wready) begin
      nxt_cur.w_got = 1'b1;
      nxt_cur.wdata = s_axi_wdata;
      nxt_cur.wstrb = s_axi_wstrb;
    end
    if (cur_ff.wst == CRB_W_IDLE) begin
      nxt_cur.awready = !nxt_cur.aw_got && !(s_axi_awvalid && cur_ff.awready);
      nxt_cur.wready = !nxt_cur.w_got && !(s_axi_wvalid && cur_ff.wready);
    end

    // write commit
    case (cur_ff.wst)
      CRB_W_IDLE: begin
        if (cur_ff.aw_got && cur_ff.w_got) begin
          nxt_cur.aw_got = 1'b0;
          nxt_cur.w_got = 1'b0;
          nxt_cur.awready = 1'b0;
          nxt_cur.wready = 1'b0;
          nxt_cur.bvalid = 1'b1;
          nxt_cur.bresp = crb_mapped(cur_ff.awaddr) ? CRB_RESP_OKAY
                                                    : CRB_RESP_SLVERR;
          nxt_cur.wst = CRB_W_RESP;
          case (cur_ff.awaddr)
            CRB_OFF_HEADER: begin
              nxt_cur.header = crb_merge(cur_ff.header, cur_ff.wdata,
                                         cur_ff.wstrb);
            end
            CRB_OFF_OPTIONS: begin
              merged = crb_merge(cur_ff.options, cur_ff.wdata,
                                 cur_ff.wstrb);
              req_spd = merged[CRB_OPT_SPD_LSB +: 3];
              if (req_spd > LINK_SPD_MAX) begin
                merged[CRB_OPT_SPD_LSB +: 3] = LINK_SPD_MAX;
              end
              nxt_cur.options = merged;
            end
            CRB_OFF_CONTROL: begin
              if (cur_ff.wstrb[0]) begin
                nxt_cur.link_en = cur_ff.wdata[CRB_CTL_LINK_EN_BIT];
                // soft reset: header and max receive kept, speed reloaded
                if (cur_ff.wdata[CRB_CTL_SOFT_RST_BIT]) begin
                  nxt_cur.link_en = 1'b0;
                  nxt_cur.options[CRB_OPT_SPD_LSB +: 3] = LINK_SPD_MAX;
                  nxt_cur.pkt_ok = 1'b0;
                  nxt_cur.pkt_type_err = 1'b0;
                  nxt_cur.pkt_spd_rej = 1'b0;
                end
              end
            end
            default: ;
          endcase
        end
      end
      CRB_W_RESP: begin
        if (s_axi_bready) begin
          nxt_cur.bvalid = 1'b0;
          nxt_cur.wst = CRB_W_IDLE;
          nxt_cur.awready = 1'b1;
          nxt_cur.wready = 1'b1;
        end
      end
      default: nxt_cur.wst = CRB_W_IDLE;
    endcase

    // read channel: one outstanding read
    if (cur_ff.rvalid) begin
      if (s_axi_rready) begin
        nxt_cur.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid && cur_ff.arready) begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rdata = crb_rd_word(s_axi_araddr, cur_ff);
      nxt_cur.rresp = crb_mapped(s_axi_araddr) ? CRB_RESP_OKAY
                                               : CRB_RESP_SLVERR;
    end else begin
      nxt_cur.arready = 1'b1;
    end

    // received packet check
    if (pkt_chk) begin
      nxt_cur.pkt_spd_rej = pkt_spd > cur_ff.options[CRB_OPT_SPD_LSB +: 3];
      nxt_cur.pkt_type_err = pkt_is_blk_wr &&
        ({1'b0, pkt_len} > crb_rec_bytes(
          cur_ff.options[CRB_OPT_MAXREC_LSB +: 4]));
      nxt_cur.pkt_ok = !nxt_cur.pkt_spd_rej && !nxt_cur.pkt_type_err &&
        ({1'b0, pkt_len} <= crb_spd_bytes(
          cur_ff.options[CRB_OPT_SPD_LSB +: 3]));
    end
  end

  // -----------------------------------------------------------------
  // state register, hard reset
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= '0;
      cur_ff.header <= CRB_HDR_HARD_RST;
      cur_ff.options <= CRB_OPT_HARD_RST;
      cur_ff.options[CRB_OPT_MAXREC_LSB +: 4] <= MAXREC_DEF;
      cur_ff.options[CRB_OPT_SPD_LSB +: 3] <= LINK_SPD_MAX;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // -----------------------------------------------------------------
  // remote quadlet reads
  // -----------------------------------------------------------------
  crb_quad_mux u_quad (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(rom_rd_req),
    .sel(rom_rd_sel),
    .header_q(cur_ff.header),
    .ident_q(bus_ident_value),
    .options_q(cur_ff.options),
    .valid(rom_rd_valid),
    .data(rom_rd_data)
  );

  // outputs straight from flops
  assign s_axi_awready = cur_ff.awready;
  assign s_axi_wready = cur_ff.wready;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_arready = cur_ff.arready;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = cur_ff.rresp;
  assign pkt_ok = cur_ff.pkt_ok;
  assign pkt_type_err = cur_ff.pkt_type_err;
  assign pkt_spd_rej = cur_ff.pkt_spd_rej;
  assign link_enable_bit = cur_ff.link_en;
  assign link_spd = cur_ff.options[CRB_OPT_SPD_LSB +: 3];
endmodule
`default_nettype wire

// [crb_regs_props.sv]
// assertions on the config rom register bank ports
`timescale 1ns/1ns
`default_nettype none
module crb_regs_props import crb_pkg::*; #(
  parameter logic [3:0] MAXREC_DEF = crb_pkg::CRB_MAXREC_DEF,
  parameter logic [2:0] LINK_SPD_MAX = crb_pkg::CRB_LINK_SPD_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // remote read and packet check
  input wire logic rom_rd_req,
  input wire logic rom_rd_valid,
  input wire logic pkt_chk,
  input wire logic [2:0] rom_rd_sel,
  input wire logic [2:0] pkt_spd,
  input wire logic [31:0] rom_rd_data,
  input wire logic pkt_ok,
  input wire logic pkt_type_err,
  input wire logic pkt_spd_rej,
  // link control
  input wire logic link_enable_bit,
  input wire logic [2:0] link_spd
);
  // ---------------------------------------------------------------
  // request steps and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence s_rom_take(logic [2:0] q);
    rom_rd_req && rom_rd_sel == q;
  endsequence
  property p_rom_answer;
    rom_rd_req |=> rom_rd_valid;
  endproperty
  property p_rom_ident;
    s_rom_take(CRB_Q_BUS_IDENTIFIER) |=> rom_rd_data == CRB_BUS_IDENT_VALUE;
  endproperty
  property p_rd_ident;
    s_ar_take(CRB_OFF_BUS_IDENTIFIER) |=>
      s_axi_rvalid && s_axi_rdata == CRB_BUS_IDENT_VALUE;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_spd_rej;
    pkt_chk |=> pkt_spd_rej == ($past(pkt_spd) > $past(link_spd));
  endproperty
  property p_ok_excl;
    pkt_ok |-> !pkt_type_err && !pkt_spd_rej;
  endproperty
  property p_spd_cap;
    link_spd <= LINK_SPD_MAX;
  endproperty
  property p_hard_rst;
    $rose(aresetn) |-> link_spd == LINK_SPD_MAX && !link_enable_bit;
  endproperty
  a_rom_answer: assert property (p_rom_answer)
    else $error("remote read not answered");
  a_rom_ident: assert property (p_rom_ident)
    else $error("remote ident quadlet wrong");
  a_rd_ident: assert property (p_rd_ident)
    else $error("ident register read wrong");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_spd_rej: assert property (p_spd_rej)
    else $error("speed reject flag wrong");
  a_ok_excl: assert property (p_ok_excl)
    else $error("packet ok with an error flag");
  a_spd_cap: assert property (p_spd_cap)
    else $error("link speed above maximum");
  a_hard_rst: assert property (p_hard_rst)
    else $error("hard reset values wrong");
endmodule
bind crb_regs crb_regs_props #(.MAXREC_DEF(MAXREC_DEF),
  .LINK_SPD_MAX(LINK_SPD_MAX)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .rom_rd_req(rom_rd_req),
  .rom_rd_valid(rom_rd_valid), .pkt_chk(pkt_chk), .rom_rd_sel(rom_rd_sel),
  .pkt_spd(pkt_spd), .rom_rd_data(rom_rd_data), .pkt_ok(pkt_ok),
  .pkt_type_err(pkt_type_err), .pkt_spd_rej(pkt_spd_rej),
  .link_enable_bit(link_enable_bit), .link_spd(link_spd));
`default_nettype wire

// [crb_regs_tb_top.sv]
// self-checking bench for the config rom register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module crb_regs_tb_top import crb_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, go;
  logic arvalid, arready, rvalid, rready, rom_req, rom_valid, pk_d;
  logic pkt_chk, blk, pk_ok, pk_te, pk_rej, lnk_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rom_data, hdr, opt;
  logic [1:0] bresp, rresp;
  logic [2:0] want, rom_sel, pkt_spd, lspd;
  logic [15:0] pkt_len;
  logic [3:0] wstrb;
  logic slow = 1'b0;
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  logic [1:0] bq[$];
  logic [2:0] pq[$];
  logic [19:0] pc[5] = '{{1'b1, 16'd512, 3'd1}, {1'b1, 16'd513, 3'd1},
    {1'b0, 16'd1024, 3'd1}, {1'b0, 16'd1025, 3'd1}, {1'b1, 16'd4, 3'd2}};
  int err_total = 0;
  int comparisons = 0;
  int seed = 59;
  always #5 aclk = ~aclk;
  crb_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rom_rd_req(rom_req), .rom_rd_sel(rom_sel),
    .rom_rd_valid(rom_valid), .rom_rd_data(rom_data), .pkt_chk(pkt_chk),
    .pkt_is_blk_wr(blk), .pkt_len(pkt_len), .pkt_spd(pkt_spd),
    .pkt_ok(pk_ok), .pkt_type_err(pk_te), .pkt_spd_rej(pk_rej),
    .link_enable_bit(lnk_en), .link_spd(lspd));
  crb_remote_node u_node (.aclk(aclk), .go(go), .want(want), .req(rom_req),
    .sel(rom_sel));
  // ---------------------------------------------------------------
  // answer watcher: oldest note against each result
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    pk_d <= pkt_chk;
    if (rvalid && rready && rq.size() > 0) begin
      `CHK("rdata", rq[0][31:0], rdata)
      `CHK("rresp", rq[0][33:32], rresp)
      void'(rq.pop_front());
    end
    if (bvalid && bready && bq.size() > 0) begin
      `CHK("bresp", bq[0], bresp)
      void'(bq.pop_front());
    end
    if (rom_valid && mq.size() > 0) begin
      `CHK("rom_data", mq[0], rom_data)
      void'(mq.pop_front());
    end
    if (pk_d && pq.size() > 0) begin
      `CHK("pkt_flags", pq[0], {pk_ok, pk_te, pk_rej})
      void'(pq.pop_front());
    end
  end
  task automatic conclude();
    `CHK("queues", 0, rq.size() + mq.size() + bq.size() + pq.size())
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      err_total++;
      $display("BAD wait exp answer got timeout");
      conclude();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ad, dd;
    n = 0;
    ad = 0;
    dd = 0;
    bq.push_back(a == 8'h20 ? CRB_RESP_SLVERR : CRB_RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    while (!(ad && dd)) begin
      tick(n);
      if (awready && !ad) awvalid <= 1'b0;
      if (wready && !dd) wvalid <= 1'b0;
      ad = ad | awready;
      dd = dd | wready;
    end
    while (!bvalid) tick(n);
    if (slow) begin
      bready <= 1'b1;
      tick(n);
    end
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rq.push_back({a == 8'h20 ? CRB_RESP_SLVERR : CRB_RESP_OKAY, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    tick(n);
    while (!arready) tick(n);
    arvalid <= 1'b0;
    tick(n);
    while (!rvalid) tick(n);
    if (slow) begin
      rready <= 1'b1;
      tick(n);
    end
  endtask
  // push one packet per cycle and note the flags it should raise
  task automatic pkt(input logic [19:0] p, input logic [2:0] sp);
    pq.push_back({!(p[2:0] > sp) && !(p[19] && p[18:3] > 16'd512) &&
      p[18:3] <= (16'd512 << sp), p[19] && p[18:3] > 16'd512, p[2:0] > sp});
    {blk, pkt_len, pkt_spd} <= p;
    pkt_chk <= 1'b1;
    @(posedge aclk);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, pkt_chk} <= '0;
    {awaddr, araddr, wdata, want, blk, pkt_len, pkt_spd} <= '0;
    wstrb <= 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(CRB_OFF_HEADER, 32'h0);
    axr(CRB_OFF_BUS_IDENTIFIER, CRB_BUS_IDENT_VALUE);
    axr(CRB_OFF_OPTIONS, {16'h0, CRB_MAXREC_DEF, 9'h0, 3'h2});
    axr(8'h20, 32'h0);
    `CHK("link_spd", 3'h2, lspd)
    $display("test reset values done");
    slow = 1'b1;
    hdr = $random(seed);
    opt = ($random(seed) & 32'hffff0ff8) | 32'h00008001;
    axw(CRB_OFF_HEADER, hdr);
    axw(CRB_OFF_OPTIONS, opt);
    axw(CRB_OFF_BUS_IDENTIFIER, 32'h0);
    axw(8'h20, 32'h0);
    axr(CRB_OFF_HEADER, hdr);
    axr(CRB_OFF_OPTIONS, opt);
    axr(CRB_OFF_BUS_IDENTIFIER, CRB_BUS_IDENT_VALUE);
    `CHK("link_spd", 3'h1, lspd)
    wstrb <= 4'h3;
    axw(CRB_OFF_HEADER, ~hdr);
    wstrb <= 4'hf;
    hdr[15:0] = ~hdr[15:0];
    axr(CRB_OFF_HEADER, hdr);
    mq = '{hdr, CRB_BUS_IDENT_VALUE, opt, 32'h0};
    for (int i = 0; i < 4; i++) begin
      go <= 1'b1;
      want <= i[2:0];
      @(posedge aclk);
    end
    go <= 1'b0;
    repeat (3) @(posedge aclk);
    $display("test header options and remote reads done");
    for (int i = 0; i < 5; i++) pkt(pc[i], 3'h1);
    pkt_chk <= 1'b0;
    repeat (2) @(posedge aclk);
    axr(CRB_OFF_STATUS, 32'h4);
    axw(CRB_OFF_CONTROL, 32'h1);
    `CHK("link_enable_bit", 1'b1, lnk_en)
    axw(CRB_OFF_CONTROL, 32'h2);
    `CHK("link_enable_bit", 1'b0, lnk_en)
    axr(CRB_OFF_HEADER, hdr);
    pkt(pc[1], 3'h2);
    pkt_chk <= 1'b0;
    repeat (2) @(posedge aclk);
    axw(CRB_OFF_OPTIONS, {opt[31:3], 3'h7});
    axr(CRB_OFF_OPTIONS, {opt[31:3], CRB_LINK_SPD_DEF});
    $display("test packets and soft reset done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(CRB_OFF_HEADER, 32'h0);
    axr(CRB_OFF_OPTIONS, {16'h0, CRB_MAXREC_DEF, 9'h0, 3'h2});
    `CHK("link_spd", 3'h2, lspd)
    $display("test hard reset done");
    repeat (4) @(posedge aclk);
    conclude();
  end
endmodule
`default_nettype wire

// [crb_remote_node.sv]
// remote node model issuing configuration rom quadlet reads
`timescale 1ns/1ns
`default_nettype none
module crb_remote_node (
  // clock
  input wire logic aclk,
  // command from the bench
  input wire logic go,
  input wire logic [2:0] want,
  // quadlet request
  output logic req,
  output logic [2:0] sel
);
  // one request cycle per go; select inverted while idle
  always_ff @(posedge aclk) begin
    req <= go;
    sel <= go ? want : ~want;
  end
endmodule
`default_nettype wire
